// File: rscko_top.sv
`timescale 1ns/1ps
`default_nettype none
module rscko_top
   import rscko_pkg::*;
(
   // clock and bus reset
   input wire logic aclk,
   input wire logic aresetn,
   // clock source selection
   input wire logic osc_present,
   input wire logic aux_tick,
   // external reset and strap
   input wire logic ext_reset,
   input wire logic external_program_select_n,
   // core timing and sequence outputs
   output logic internal_reset,
   output logic fetch_address_drive,
   output logic ale_fall,
   output logic [PH_W-1:0] phase_index,
   output logic machine_cycle_end,
   // port pin
   output logic port_one_bit_six,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      reg_hit = (a == OFS_PORT_LATCH) || (a == OFS_STATUS) ||
                (a == OFS_SYS_CTRL) || (a == OFS_CONV_CTRL0);
   endfunction

   logic tick;
   logic [PH_W-1:0] ph_q;
   logic rst_s1_q;
   logic rst_s2_q;
   rscko_seq_t seq_q;
   logic [RST_CNT_W-1:0] rcnt_q;
   logic [SLOW_W-1:0] slow_q;
   logic clk_phase_q;
   logic [7:0] port_latch_q;
   logic [7:0] conv_ctrl_q;
   logic [7:0] sys_ctrl_q;
   logic load_defaults;
   logic aw_have_q;
   logic w_have_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_write;
   rscko_status_t status;

   // without an oscillator the watchdog's ticks step the sequence
   assign tick = osc_present ? 1'b1 : aux_tick;

   // twelve-phase machine cycle counter
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ph_q <= '0;
      else if (tick)
         ph_q <= (ph_q == PH_LAST) ? '0 : ph_q + 1'b1;
   end

   assign phase_index = ph_q;
   assign machine_cycle_end = tick && (ph_q == PH_LAST);

   // phase-clock synchroniser; only the second stage is used
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else if (tick)
      begin
         rst_s1_q <= ext_reset;
         rst_s2_q <= rst_s1_q;
      end
   end

   // reset and start-up sequence
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         seq_q <= SEQ_PROC;
         rcnt_q <= '0;
      end
      else if (tick)
      begin
         case (seq_q)
            SEQ_PROC:
            begin
               // full two-cycle procedure regardless of release
               if (rcnt_q == RST_CNT_W'(RST_TICKS - 1))
                  seq_q <= rst_s2_q ? SEQ_HOLD : SEQ_RECOG;
               else
                  rcnt_q <= rcnt_q + 1'b1;
            end
            SEQ_HOLD:
            begin
               // held in reset while the input stays high
               if (!rst_s2_q)
                  seq_q <= SEQ_RECOG;
            end
            SEQ_RECOG:
            begin
               if (rst_s2_q)
                  seq_q <= SEQ_HOLD;
               else if (ph_q == PH_S5P2)
                  seq_q <= SEQ_ADDR;
            end
            SEQ_ADDR:
            begin
               if (ph_q == PH_S5P1)
                  seq_q <= SEQ_ALE;
            end
            SEQ_ALE:
               seq_q <= SEQ_RUN;
            SEQ_RUN:
            begin
               // a fresh high level restarts the whole procedure
               if (rst_s2_q)
               begin
                  seq_q <= SEQ_PROC;
                  rcnt_q <= '0;
               end
            end
            default:
            begin
               seq_q <= SEQ_PROC;
               rcnt_q <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         internal_reset <= 1'b1;
      else
         internal_reset <= (seq_q == SEQ_PROC) || (seq_q == SEQ_HOLD) ||
                           (seq_q == SEQ_RECOG);
   end

   // address drive only with external program memory
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fetch_address_drive <= 1'b0;
      else
         fetch_address_drive <= !external_program_select_n &&
            (((seq_q == SEQ_ADDR) && (ph_q == PH_S5P1)) ||
             (seq_q == SEQ_ALE) || (seq_q == SEQ_RUN));
   end

   // first falling edge of the address-latch strobe, one phase later
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ale_fall <= 1'b0;
      else
         ale_fall <= tick && !external_program_select_n &&
                     (seq_q == SEQ_ALE) && (ph_q == PH_S5P2);
   end

   // defaults are reloaded on every step of the procedure
   assign load_defaults = tick && (seq_q == SEQ_PROC);

   // slow-down: clock output fires only every 32nd machine cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         slow_q <= '0;
      else if (machine_cycle_end)
         slow_q <= slow_q + 1'b1;
   end

   // high in S3P1 and S3P2 only; S3 also ends each data-move strobe
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clk_phase_q <= 1'b0;
      else
         clk_phase_q <= ((ph_q == PH_S3P1) || (ph_q == PH_S3P2)) &&
            (!sys_ctrl_q[SLOW_EN_BIT] || (slow_q == '0));
   end

   // pin mux; a zero latch pulls the pin low whatever the enable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         port_one_bit_six <= PORT_LATCH_RST[PIN_BIT];
      else if (conv_ctrl_q[SYSTEM_CLOCK_OUTPUT_PIN_EN_BIT])
         port_one_bit_six <= port_latch_q[PIN_BIT] & clk_phase_q;
      else
         port_one_bit_six <= port_latch_q[PIN_BIT];
   end

   // axi write channel capture, either order
   assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
   assign s_axi_wready = !w_have_q && !s_axi_bvalid;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         awaddr_q <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_q <= 1'b1;
         awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
         aw_have_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
         w_have_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // registers; the reset procedure overrides a concurrent write
   always_ff @(posedge aclk)
   begin
      if (!aresetn || load_defaults)
         port_latch_q <= PORT_LATCH_RST;
      else if (do_write && wstrb_q[0] && (awaddr_q == OFS_PORT_LATCH))
         port_latch_q <= wdata_q[7:0];
   end

   // reserved bits simply keep what was written
   always_ff @(posedge aclk)
   begin
      if (!aresetn || load_defaults)
         conv_ctrl_q <= CONV_CTRL0_RST;
      else if (do_write && wstrb_q[0] && (awaddr_q == OFS_CONV_CTRL0))
         conv_ctrl_q <= wdata_q[7:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || load_defaults)
         sys_ctrl_q <= SYS_CTRL_RST;
      else if (do_write && wstrb_q[0] && (awaddr_q == OFS_SYS_CTRL))
         sys_ctrl_q <= wdata_q[7:0];
   end

   assign status.phase_idx = ph_q;
   assign status.slow_active = sys_ctrl_q[SLOW_EN_BIT];
   assign status.fetch_active = (seq_q == SEQ_RUN);
   assign status.in_reset = internal_reset;

   // axi read channel; one read outstanding
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            OFS_PORT_LATCH: s_axi_rdata <= {24'h000000, port_latch_q};
            OFS_STATUS: s_axi_rdata <= {25'h0000000, status};
            OFS_SYS_CTRL: s_axi_rdata <= {24'h000000, sys_ctrl_q};
            OFS_CONV_CTRL0: s_axi_rdata <= {24'h000000, conv_ctrl_q};
            default: s_axi_rdata <= 32'h00000000;
         endcase
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule
`default_nettype wire

// File: rscko_pkg.sv
`default_nettype none
package rscko_pkg;

   // machine timing: six states of two phases per machine cycle
   localparam int unsigned PH_PER_MC = 12;
   localparam int unsigned PH_W = 4;
   localparam logic [PH_W-1:0] PH_LAST = 4'hB;
   localparam logic [PH_W-1:0] PH_S3P1 = 4'h4;
   localparam logic [PH_W-1:0] PH_S3P2 = 4'h5;
   localparam logic [PH_W-1:0] PH_S5P1 = 4'h8;
   localparam logic [PH_W-1:0] PH_S5P2 = 4'h9;

   // reset procedure length in machine cycles, and in oscillator ticks
   localparam int unsigned RST_MC = 2;
   localparam int unsigned RST_TICKS = RST_MC * PH_PER_MC;
   localparam int unsigned RST_CNT_W = 5;

   // slow-down divider for the clock output
   localparam int unsigned SLOW_DIV = 32;
   localparam int unsigned SLOW_W = 5;

   // register map, byte addresses
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFS_PORT_LATCH = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SYS_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_CONV_CTRL0 = 8'hD8;

   // field layout and reset values
   localparam int unsigned SYSTEM_CLOCK_OUTPUT_PIN_EN_BIT = 6;
   localparam int unsigned PIN_BIT = 6;
   localparam int unsigned SLOW_EN_BIT = 0;
   localparam logic [7:0] PORT_LATCH_RST = 8'hFF;
   localparam logic [7:0] CONV_CTRL0_RST = 8'h00;
   localparam logic [7:0] SYS_CTRL_RST = 8'h00;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [5:0] {
      SEQ_PROC = 6'h01,
      SEQ_HOLD = 6'h02,
      SEQ_RECOG = 6'h04,
      SEQ_ADDR = 6'h08,
      SEQ_ALE = 6'h10,
      SEQ_RUN = 6'h20
   } rscko_seq_t;

   typedef struct packed {
      logic [PH_W-1:0] phase_idx;
      logic slow_active;
      logic fetch_active;
      logic in_reset;
   } rscko_status_t;

endpackage
`default_nettype wire

// File: rscko_props.sv
`timescale 1ns/1ps
`default_nettype none
module rscko_props
   import rscko_pkg::*;
(
   // clock, reset and tick sources
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic osc_present,
   input wire logic aux_tick,
   input wire logic ext_reset,
   // sequence outputs
   input wire logic internal_reset,
   input wire logic fetch_address_drive,
   input wire logic ale_fall,
   input wire logic [PH_W-1:0] phase_index,
   input wire logic machine_cycle_end,
   // read channel
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   // ticks since pin release; saturates so stale ales still fail
   logic [5:0] rel_q;
   always_ff @(posedge aclk)
      if (!aresetn || ext_reset)
         rel_q <= 6'h00;
      else if ((osc_present || aux_tick) && rel_q != 6'h3F)
         rel_q <= rel_q + 6'h01;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_RST_PROC: assert property ($rose(aresetn) |-> internal_reset [*8])
      else $error("reset procedure cut short");
   AST_PH_HOLD: assert property (!(osc_present || aux_tick) |=> $stable(phase_index))
      else $error("phase moved without a tick");
   AST_PH_STEP: assert property (aresetn && osc_present &&
      phase_index != PH_LAST |=> phase_index == $past(phase_index) + 4'h1)
      else $error("phase did not step");
   AST_MC_WRAP: assert property (machine_cycle_end |=> phase_index == 4'h0)
      else $error("machine cycle not twelve phases");
   AST_EXT_HOLD: assert property ((ext_reset && osc_present) [*5] |-> internal_reset)
      else $error("reset pin high but device running");
   AST_NO_FETCH: assert property (internal_reset |-> !fetch_address_drive && !ale_fall)
      else $error("fetch during reset");
   AST_ALE_WIN: assert property (ale_fall |-> rel_q >= 6'd12 && rel_q <= 6'd28)
      else $error("first ale fall outside window");
   AST_ALE_FETCH: assert property (ale_fall |-> fetch_address_drive ##1 !ale_fall)
      else $error("ale fall without address drive");
   AST_ADDR_FIRST: assert property (ale_fall |-> $past(fetch_address_drive))
      else $error("address not driven a phase before ale fall");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule
bind rscko_top rscko_props u_props (.aclk, .aresetn, .osc_present, .aux_tick,
   .ext_reset, .internal_reset, .fetch_address_drive, .ale_fall, .phase_index,
   .machine_cycle_end, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
`default_nettype wire

// File: rscko_ext.sv
`timescale 1ns/1ps
`default_nettype none
module rscko_ext
   import rscko_pkg::*;
#(
   parameter int HOLD = PH_PER_MC
)
(
   // clock
   input wire logic aclk,
   // reset request and consumed clock
   input wire logic req,
   input wire logic clk_in,
   output logic ext_reset,
   output logic [15:0] edges
);
   logic [7:0] hold_q;
   logic last_q;
   initial edges = 16'h0000;
   // stretch so a short request still spans a machine cycle
   always @(posedge aclk)
      if (req)
         hold_q <= 8'(HOLD);
      else if (hold_q != 8'h00)
         hold_q <= hold_q - 8'h01;
   assign ext_reset = req || hold_q != 8'h00;
   always @(posedge aclk)
   begin
      last_q <= clk_in;
      if (clk_in && !last_q)
         edges <= edges + 16'h0001;
   end
endmodule
`default_nettype wire

// File: rscko_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rscko_tb;
   import rscko_pkg::*;
   logic aclk, aresetn, osc, aux, req, sel_n, ext, irst, fad, ale, mce, pin;
   logic awv, wv, bry, arv, rry, awr, wrdy, bv, arr, rv;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, q;
   logic [1:0] bresp, rresp, r;
   logic [3:0] ph;
   logic [15:0] edges, e0;
   int errors, checks_done, cyc, n, hi;
   rscko_top DUT (.aclk(aclk), .aresetn(aresetn), .osc_present(osc),
      .aux_tick(aux), .ext_reset(ext), .external_program_select_n(sel_n),
      .internal_reset(irst), .fetch_address_drive(fad), .ale_fall(ale),
      .phase_index(ph), .machine_cycle_end(mce), .port_one_bit_six(pin),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(rry));
   rscko_ext PEER (.aclk(aclk), .req(req), .clk_in(pin), .ext_reset(ext),
      .edges(edges));
   always #10 aclk = ~aclk;
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("ERROR %0t: got %h exp %h", $time, s, e);
      end
   endtask
   task final_report;
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // clock output highs: two phases per visible machine cycle
   function int exp_hi(int c, bit slow);
      return (slow ? c / (PH_PER_MC * SLOW_DIV) : c / PH_PER_MC) * 2;
   endfunction
   task automatic bus(input bit we, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] qo, output logic [1:0] ro);
      bit pa, pd, t1, t2;
      pa = 1'b1;
      pd = we;
      @(posedge aclk);
      awa <= a;
      ara <= a;
      wd <= d;
      awv <= we;
      wv <= we;
      bry <= we;
      arv <= !we;
      rry <= !we;
      while (pa || pd)
      begin
         @(negedge aclk);
         t1 = we ? awr : arr;
         t2 = wrdy;
         @(posedge aclk);
         if (t1 && pa)
         begin
            pa = 1'b0;
            awv <= 1'b0;
            arv <= 1'b0;
         end
         if (t2 && pd)
         begin
            pd = 1'b0;
            wv <= 1'b0;
         end
      end
      t1 = 1'b0;
      while (!t1)
      begin
         @(negedge aclk);
         t1 = we ? bv : rv;
         qo = rd;
         ro = we ? bresp : rresp;
         @(posedge aclk);
      end
      bry <= 1'b0;
      rry <= 1'b0;
   endtask
   // whole periods in the window, so alignment does not matter
   task meas(input int c, input int ehi, input int eed);
      hi = 0;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      e0 = edges;
      repeat (c)
      begin
         hi += pin;
         @(negedge aclk);
      end
      chk(hi, ehi);
      chk(32'(edges - e0), eed);
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      aux <= $urandom_range(0, 2) == 0;
      if (cyc == 10000)
      begin
         errors++;
         final_report;
      end
   end
   initial
   begin
      void'($urandom(40430));
      {aclk, aresetn, aux, sel_n, awv, wv, bry, arv, rry} = '0;
      {osc, req, awa, ara, wd, errors, checks_done, cyc} = '0;
      osc = 1'b1;
      req = 1'b1;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      bus(0, OFS_PORT_LATCH, 0, q, r);
      chk(q, 32'(PORT_LATCH_RST));
      bus(0, OFS_CONV_CTRL0, 0, q, r);
      chk(q, 32'(CONV_CTRL0_RST));
      bus(0, 8'h40, 0, q, r);
      chk(32'(r), 32'(RESP_SLVERR));
      chk(irst, 1);
      req <= 1'b0;
      // the peer stretches the request; time from the pin itself
      n = 0;
      while (n < 100 && ext !== 1'b0)
      begin
         @(negedge aclk);
         n++;
      end
      n = 0;
      while (n < 100 && ale !== 1'b1)
      begin
         @(negedge aclk);
         n++;
      end
      chk(n >= PH_PER_MC && n < 2 * PH_PER_MC + 6, 1);
      chk(fad, 1);
      chk(irst, 0);
      bus(1, OFS_CONV_CTRL0, $urandom | 32'h40, q, r);
      chk(32'(r), 32'(RESP_OKAY));
      bus(0, OFS_CONV_CTRL0, 0, q, r);
      chk(q[SYSTEM_CLOCK_OUTPUT_PIN_EN_BIT], 1);
      meas(120, exp_hi(120, 0), 10);
      bus(1, OFS_SYS_CTRL, 1, q, r);
      meas(768, exp_hi(768, 1), 2);
      bus(1, OFS_SYS_CTRL, 0, q, r);
      bus(1, OFS_PORT_LATCH, 32'hBF, q, r);
      meas(48, 0, 0);
      bus(1, OFS_CONV_CTRL0, 0, q, r);
      bus(1, OFS_PORT_LATCH, 32'hFF, q, r);
      meas(48, 48, 0);
      bus(1, OFS_PORT_LATCH, 0, q, r);
      sel_n <= 1'b1;
      osc <= 1'b0;
      req <= 1'b1;
      repeat (300) @(posedge aclk);
      chk(irst, 1);
      req <= 1'b0;
      n = 0;
      while (n < 1000 && irst !== 1'b0)
      begin
         @(negedge aclk);
         n++;
      end
      chk(irst, 0);
      bus(0, OFS_PORT_LATCH, 0, q, r);
      chk(q, 32'(PORT_LATCH_RST));
      chk(pin, 1);
      chk(fad, 0);
      final_report;
   end
endmodule
`default_nettype wire
